// >>> exip_pkg.sv
package exip_pkg;

   // Register offsets
   localparam logic [7:0] EXIP_OFS_LINE_SENS_LO = 8'h00;
   localparam logic [7:0] EXIP_OFS_LINE_SENS_HI = 8'h01;
   localparam logic [7:0] EXIP_OFS_PORT_SENS    = 8'h02;
   localparam logic [7:0] EXIP_OFS_LINE_FLAGS   = 8'h03;
   localparam logic [7:0] EXIP_OFS_PORT_FLAGS   = 8'h04;
   localparam logic [7:0] EXIP_OFS_ROUTE_A      = 8'h05;
   localparam logic [7:0] EXIP_OFS_GH_SENS      = 8'h0A;
   localparam logic [7:0] EXIP_OFS_ROUTE_B      = 8'h0B;

   // Reset value shared by every register
   localparam logic [7:0] EXIP_REG_RESET = 8'h00;

   // Writable bits of the registers with reserved fields
   localparam logic [7:0] EXIP_GH_SENS_MASK   = 8'h0F;
   localparam logic [7:0] EXIP_ROUTE_B_MASK   = 8'h7F;
   localparam logic [7:0] EXIP_PORT_FLAG_MASK = 8'h3F;
   localparam logic [7:0] EXIP_PORT_FLAG_MED  = 8'h0F;

   // Field positions in port_gh_sensitivity
   localparam int EXIP_G_SENS_POS = 0;
   localparam int EXIP_H_SENS_POS = 2;

   // Field positions in port_sensitivity (B, D, E, F)
   localparam int EXIP_B_SENS_POS = 0;
   localparam int EXIP_D_SENS_POS = 2;
   localparam int EXIP_E_SENS_POS = 4;
   localparam int EXIP_F_SENS_POS = 6;

   // Bit positions in port_flags
   localparam int EXIP_FLAG_B = 0;
   localparam int EXIP_FLAG_D = 1;
   localparam int EXIP_FLAG_E = 2;
   localparam int EXIP_FLAG_F = 3;
   localparam int EXIP_FLAG_G = 4;
   localparam int EXIP_FLAG_H = 5;

   // Bit positions in port_route_select_a
   localparam int EXIP_B_LOW_ROUTE     = 0;
   localparam int EXIP_B_HIGH_ROUTE    = 1;
   localparam int EXIP_D_LOW_ROUTE     = 2;
   localparam int EXIP_D_HIGH_ROUTE    = 3;
   localparam int EXIP_E_LOW_ROUTE     = 4;
   localparam int EXIP_E_HIGH_ROUTE    = 5;
   localparam int EXIP_F_LOW_ROUTE     = 6;
   localparam int EXIP_EF_SOURCE       = 7;

   // Bit positions in port_route_select_b
   localparam int EXIP_F_HIGH_ROUTE    = 0;
   localparam int EXIP_G_LOW_ROUTE     = 1;
   localparam int EXIP_G_HIGH_ROUTE    = 2;
   localparam int EXIP_H_LOW_ROUTE     = 3;
   localparam int EXIP_H_HIGH_ROUTE    = 4;
   localparam int EXIP_BG_SOURCE       = 5;
   localparam int EXIP_DH_SOURCE       = 6;

   // Trigger encodings
   typedef enum logic [1:0] {
      EXIP_TRIG_FALL_LOW = 2'b00,
      EXIP_TRIG_RISE     = 2'b01,
      EXIP_TRIG_FALL     = 2'b10,
      EXIP_TRIG_BOTH     = 2'b11
   } exip_trig_t;

   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } exip_bus_req_t;

   typedef struct packed {
      logic [7:0] h;
      logic [7:0] g;
      logic [7:0] f;
      logic [7:0] e;
      logic [7:0] d;
      logic [7:0] c;
      logic [7:0] b;
      logic [7:0] a;
   } exip_pins_t;

   typedef struct packed {
      logic [7:0] line_pending;
      logic       bg;
      logic       dh;
      logic       ef;
   } exip_irq_t;

   typedef struct packed {
      logic [7:0] line_sens_lo;
      logic [7:0] line_sens_hi;
      logic [7:0] port_sens;
      logic [7:0] line_flags;
      logic [7:0] port_flags;
      logic [7:0] route_a;
      logic [7:0] gh_sens;
      logic [7:0] route_b;
      exip_pins_t pins_prev;
      logic       prev_ok;
      logic [7:0] rdata;
   } exip_state_t;

   localparam exip_state_t EXIP_STATE_RESET = '0;

endpackage

// >>> exip_ext_irq.sv
`timescale 1ns/1ps

module exip_ext_irq
   import exip_pkg::*;
#(
   parameter bit LARGE_VARIANT = 1'b1
) (
   input  wire logic          clock,
   input  wire logic          rst,
   input  wire exip_bus_req_t bus_req,
   output logic [7:0]         bus_rdata,
   input  wire logic          cpu_mask_high,
   input  wire logic          cpu_mask_low,
   input  wire exip_pins_t    pins,
   output exip_irq_t          irq
);

   exip_state_t s_q;
   exip_state_t s_d;

   // Event qualifier for one pin under a trigger code
   function automatic logic trig_hit(input logic [1:0] sens,
                                     input logic       prev,
                                     input logic       cur,
                                     input logic       prev_ok);
      logic rise;
      logic fall;
      logic hit;
      rise = prev_ok & ~prev & cur;
      fall = prev_ok & prev & ~cur;
      unique case (exip_trig_t'(sens))
         EXIP_TRIG_FALL_LOW: hit = ~cur;
         EXIP_TRIG_RISE:     hit = rise;
         EXIP_TRIG_FALL:     hit = fall;
         EXIP_TRIG_BOTH:     hit = rise | fall;
      endcase
      return hit;
   endfunction

   // Any hit on the routed halves of one port
   function automatic logic port_hit(input logic [1:0] sens,
                                     input logic [7:0] prev,
                                     input logic [7:0] cur,
                                     input logic       prev_ok,
                                     input logic       lo_sel,
                                     input logic       hi_sel);
      logic hit;
      hit = 1'b0;
      for (int i = 0; i < 8; i++) begin
         if ((i < 4) ? lo_sel : hi_sel) begin
            hit = hit | trig_hit(sens, prev[i], cur[i], prev_ok);
         end
      end
      return hit;
   endfunction

   logic       sens_unlocked;
   logic [5:0] port_event;
   logic [7:0] line_event;
   logic [7:0] line_src;
   logic [7:0] prev_src;
   logic [7:0] rd_val;
   logic [7:0] w1c;
   logic [7:0] pflag_mask;
   logic [1:0] ls;
   logic [7:0] ra;
   logic [7:0] rb;
   logic       lo;

   assign pflag_mask = LARGE_VARIANT ? EXIP_PORT_FLAG_MASK : EXIP_PORT_FLAG_MED;

   always_comb begin
      s_d           = s_q;
      ra            = s_q.route_a;
      rb            = s_q.route_b;
      sens_unlocked = cpu_mask_high & cpu_mask_low;

      // Port interrupt events, each with its own port trigger field
      port_event = '0;
      port_event[EXIP_FLAG_B] = port_hit(s_q.port_sens[EXIP_B_SENS_POS +: 2],
         s_q.pins_prev.b, pins.b, s_q.prev_ok,
         ra[EXIP_B_LOW_ROUTE], ra[EXIP_B_HIGH_ROUTE]);
      port_event[EXIP_FLAG_D] = port_hit(s_q.port_sens[EXIP_D_SENS_POS +: 2],
         s_q.pins_prev.d, pins.d, s_q.prev_ok,
         ra[EXIP_D_LOW_ROUTE], ra[EXIP_D_HIGH_ROUTE]);
      port_event[EXIP_FLAG_E] = port_hit(s_q.port_sens[EXIP_E_SENS_POS +: 2],
         s_q.pins_prev.e, pins.e, s_q.prev_ok,
         ra[EXIP_E_LOW_ROUTE], ra[EXIP_E_HIGH_ROUTE]);
      port_event[EXIP_FLAG_F] = port_hit(s_q.port_sens[EXIP_F_SENS_POS +: 2],
         s_q.pins_prev.f, pins.f, s_q.prev_ok,
         ra[EXIP_F_LOW_ROUTE], rb[EXIP_F_HIGH_ROUTE]);
      port_event[EXIP_FLAG_G] = port_hit(s_q.gh_sens[EXIP_G_SENS_POS +: 2],
         s_q.pins_prev.g, pins.g, s_q.prev_ok,
         rb[EXIP_G_LOW_ROUTE], rb[EXIP_G_HIGH_ROUTE]);
      port_event[EXIP_FLAG_H] = port_hit(s_q.gh_sens[EXIP_H_SENS_POS +: 2],
         s_q.pins_prev.h, pins.h, s_q.prev_ok,
         rb[EXIP_H_LOW_ROUTE], rb[EXIP_H_HIGH_ROUTE]);
      if (!LARGE_VARIANT) begin
         port_event[EXIP_FLAG_G] = 1'b0;
         port_event[EXIP_FLAG_H] = 1'b0;
      end

      // Pin-line events; ports A and C always feed the lines
      line_event = '0;
      for (int x = 0; x < 8; x++) begin
         lo = (x < 4);
         ls = (x < 4) ? s_q.line_sens_lo[2*(x%4) +: 2] : s_q.line_sens_hi[2*(x%4) +: 2];
         line_src = '0;
         prev_src = '0;
         line_src[0] = pins.a[x];
         prev_src[0] = s_q.pins_prev.a[x];
         line_src[1] = pins.c[x];
         prev_src[1] = s_q.pins_prev.c[x];
         line_src[2] = pins.b[x];
         prev_src[2] = s_q.pins_prev.b[x];
         line_src[3] = pins.d[x];
         prev_src[3] = s_q.pins_prev.d[x];
         line_src[4] = pins.e[x];
         prev_src[4] = s_q.pins_prev.e[x];
         line_src[5] = pins.f[x];
         prev_src[5] = s_q.pins_prev.f[x];
         line_src[6] = pins.g[x];
         prev_src[6] = s_q.pins_prev.g[x];
         line_src[7] = pins.h[x];
         prev_src[7] = s_q.pins_prev.h[x];
         for (int p = 0; p < 8; p++) begin
            logic routed;
            routed = 1'b1;
            unique case (p)
               2: routed = ~(lo ? ra[EXIP_B_LOW_ROUTE] : ra[EXIP_B_HIGH_ROUTE]);
               3: routed = ~(lo ? ra[EXIP_D_LOW_ROUTE] : ra[EXIP_D_HIGH_ROUTE]);
               4: routed = ~(lo ? ra[EXIP_E_LOW_ROUTE] : ra[EXIP_E_HIGH_ROUTE]);
               5: routed = ~(lo ? ra[EXIP_F_LOW_ROUTE] : rb[EXIP_F_HIGH_ROUTE]);
               6: routed = ~(lo ? rb[EXIP_G_LOW_ROUTE] : rb[EXIP_G_HIGH_ROUTE]);
               7: routed = ~(lo ? rb[EXIP_H_LOW_ROUTE] : rb[EXIP_H_HIGH_ROUTE]);
               default: routed = 1'b1;
            endcase
            // Ports G and H are not bonded out on the smaller variant
            if (!LARGE_VARIANT && p >= 6) begin
               routed = 1'b0;
            end
            if (routed && trig_hit(ls, prev_src[p], line_src[p], s_q.prev_ok)) begin
               line_event[x] = 1'b1;
            end
         end
      end

      s_d.pins_prev = pins;
      s_d.prev_ok   = 1'b1;

      // Register writes
      w1c = '0;
      if (bus_req.wr) begin
         unique case (bus_req.addr)
            EXIP_OFS_LINE_SENS_LO: begin
               if (sens_unlocked) s_d.line_sens_lo = bus_req.wdata;
            end
            EXIP_OFS_LINE_SENS_HI: begin
               if (sens_unlocked) s_d.line_sens_hi = bus_req.wdata;
            end
            EXIP_OFS_PORT_SENS: begin
               if (sens_unlocked) s_d.port_sens = bus_req.wdata;
            end
            EXIP_OFS_ROUTE_A: s_d.route_a = bus_req.wdata;
            EXIP_OFS_GH_SENS: begin
               if (LARGE_VARIANT && sens_unlocked) begin
                  s_d.gh_sens = bus_req.wdata & EXIP_GH_SENS_MASK;
               end
            end
            EXIP_OFS_ROUTE_B: begin
               if (LARGE_VARIANT) s_d.route_b = bus_req.wdata & EXIP_ROUTE_B_MASK;
            end
            default: w1c = bus_req.wdata;
         endcase
      end

      // Flags: a set in the same cycle as its clear wins
      s_d.line_flags = line_event |
         (s_q.line_flags & ~((bus_req.wr && bus_req.addr == EXIP_OFS_LINE_FLAGS) ?
          w1c : 8'h00));
      s_d.port_flags = ({2'b00, port_event} |
         (s_q.port_flags & ~((bus_req.wr && bus_req.addr == EXIP_OFS_PORT_FLAGS) ?
          w1c : 8'h00))) & pflag_mask;

      // Register reads, data stand the cycle after the strobe
      unique case (bus_req.addr)
         EXIP_OFS_LINE_SENS_LO: rd_val = s_q.line_sens_lo;
         EXIP_OFS_LINE_SENS_HI: rd_val = s_q.line_sens_hi;
         EXIP_OFS_PORT_SENS:    rd_val = s_q.port_sens;
         EXIP_OFS_LINE_FLAGS:   rd_val = s_q.line_flags;
         EXIP_OFS_PORT_FLAGS:   rd_val = s_q.port_flags;
         EXIP_OFS_ROUTE_A:      rd_val = s_q.route_a;
         EXIP_OFS_GH_SENS:      rd_val = s_q.gh_sens;
         EXIP_OFS_ROUTE_B:      rd_val = s_q.route_b;
         default:               rd_val = 8'h00;
      endcase
      s_d.rdata = bus_req.rd ? rd_val : 8'h00;
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         s_q <= EXIP_STATE_RESET;
      end else begin
         s_q <= s_d;
      end
   end

   assign bus_rdata        = s_q.rdata;
   assign irq.line_pending = s_q.line_flags;
   assign irq.ef = s_q.route_a[EXIP_EF_SOURCE] ? s_q.port_flags[EXIP_FLAG_F]
                                               : s_q.port_flags[EXIP_FLAG_E];
   assign irq.dh = s_q.route_b[EXIP_DH_SOURCE] ? s_q.port_flags[EXIP_FLAG_H]
                                               : s_q.port_flags[EXIP_FLAG_D];
   assign irq.bg = s_q.route_b[EXIP_BG_SOURCE] ? s_q.port_flags[EXIP_FLAG_G]
                                               : s_q.port_flags[EXIP_FLAG_B];

endmodule

// >>> exip_ext_irq_chk.sv
`timescale 1ns/1ps
module exip_ext_irq_chk
   import exip_pkg::*;
#(
   parameter bit LARGE_VARIANT = 1'b1
) (
   input wire logic          clock,
   input wire logic          rst,
   input wire exip_bus_req_t bus_req,
   input wire logic [7:0]    bus_rdata,
   input wire logic          cpu_mask_high,
   input wire logic          cpu_mask_low,
   input wire exip_pins_t    pins,
   input wire exip_irq_t     irq
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);
   wire logic [7:0] clr_bits = (bus_req.wr && bus_req.addr == EXIP_OFS_LINE_FLAGS) ?
                               bus_req.wdata : 8'h00;
   // Bit high on every port in two samples: no trigger code can fire there
   function automatic logic [7:0] quiet(input exip_pins_t c, input exip_pins_t p);
      return c.a & p.a & c.b & p.b & c.c & p.c & c.d & p.d &
             c.e & p.e & c.f & p.f & c.g & p.g & c.h & p.h;
   endfunction
   sequence s_rd(logic [7:0] a);
      bus_req.rd && bus_req.addr == a;
   endsequence
   rdata_idle_a: assert property (!bus_req.rd |=> bus_rdata == 8'h00)
      else $error("read data outside the read slot");
   line_read_a: assert property (s_rd(EXIP_OFS_LINE_FLAGS) |=>
      bus_rdata == $past(irq.line_pending)) else $error("line flag read mismatch");
   resv_sr2_a: assert property (s_rd(EXIP_OFS_PORT_FLAGS) |=> bus_rdata[7:6] == 2'b00)
      else $error("reserved port flag bits set");
   resv_gh_a: assert property (s_rd(EXIP_OFS_GH_SENS) |=> bus_rdata[7:4] == 4'h0)
      else $error("reserved trigger bits set");
   resv_rtb_a: assert property (s_rd(EXIP_OFS_ROUTE_B) |=> !bus_rdata[7])
      else $error("reserved route bit set");
   unmapped_a: assert property (bus_req.rd && bus_req.addr inside {[8'h06:8'h09]} |=>
      bus_rdata == 8'h00) else $error("unmapped read not zero");
   line_hold_a: assert property ((~irq.line_pending & $past(irq.line_pending) &
      ~$past(clr_bits)) == 8'h00) else $error("line flag dropped without clear");
   line_cause_a: assert property ((irq.line_pending & ~$past(irq.line_pending) &
      quiet($past(pins), $past(pins, 2))) == 8'h00) else $error("line flag set without event");
endmodule

bind exip_ext_irq exip_ext_irq_chk #(.LARGE_VARIANT(LARGE_VARIANT)) i_chk (
   .clock(clock), .rst(rst), .bus_req(bus_req), .bus_rdata(bus_rdata),
   .cpu_mask_high(cpu_mask_high), .cpu_mask_low(cpu_mask_low), .pins(pins), .irq(irq));

// >>> exip_pin_model.sv
`timescale 1ns/1ps
module exip_pin_model
   import exip_pkg::*;
(
   input  wire logic       clock,
   input  wire logic       rst,
   input  wire exip_pins_t drive,
   output exip_pins_t      pins
);
   // Reset holds every pin high; afterwards each pin follows drive one clock later
   always_ff @(posedge clock) begin
      if (rst) begin
         pins <= '1;
      end else begin
         pins <= drive;
      end
   end
endmodule

// >>> exip_ext_irq_test.sv
`timescale 1ns/1ps
module exip_ext_irq_test
   import exip_pkg::*;
;
   logic          clock;
   logic          rst;
   exip_bus_req_t bus_req;
   logic [7:0]    bus_rdata;
   logic          cpu_mask_high;
   logic          cpu_mask_low;
   exip_pins_t    drive;
   exip_pins_t    pins;
   exip_irq_t     irq;
   logic [7:0]    med_rdata;
   exip_irq_t     med_irq;
   int            n_fail = 0;
   int            tests_run = 0;
   int            cycles = 0;
   logic [7:0]    ra [6] = '{8'h01, 8'h04, 8'h10, 8'hC0, 8'h00, 8'h00};
   logic [7:0]    rb [6] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h22, 8'h48};
   int            pbyte [6] = '{1, 3, 4, 5, 6, 7};
   logic [2:0]    eirq [6] = '{3'b100, 3'b010, 3'b001, 3'b001, 3'b100, 3'b010};

   exip_pin_model i_pins (.clock(clock), .rst(rst), .drive(drive), .pins(pins));
   exip_ext_irq #(.LARGE_VARIANT(1'b1)) i_dut (
      .clock(clock), .rst(rst), .bus_req(bus_req), .bus_rdata(bus_rdata),
      .cpu_mask_high(cpu_mask_high), .cpu_mask_low(cpu_mask_low), .pins(pins), .irq(irq));
   // Medium variant shares every input: G/H registers must stay absent
   exip_ext_irq #(.LARGE_VARIANT(1'b0)) i_med (
      .clock(clock), .rst(rst), .bus_req(bus_req), .bus_rdata(med_rdata),
      .cpu_mask_high(cpu_mask_high), .cpu_mask_low(cpu_mask_low), .pins(pins),
      .irq(med_irq));

   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_fail++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // Strobe drops one edge before the next request, so no signal is set twice at once
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      bus_req.wr <= 1'b1;
      bus_req.addr <= a;
      bus_req.wdata <= d;
      @(posedge clock);
      bus_req.wr <= 1'b0;
      @(posedge clock);
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      bus_req.rd <= 1'b1;
      bus_req.addr <= a;
      @(posedge clock);
      bus_req.rd <= 1'b0;
      #1 check(bus_rdata, e);
      @(posedge clock);
   endtask

   initial begin
      clock = 1'b0;
      forever #12.5 clock = ~clock;
   end
   always @(posedge clock) begin
      cycles++;
      if (cycles == 2000) begin
         n_fail++;
         print_verdict();
      end
   end
   initial begin
      rst = 1'b1;
      bus_req = '0;
      cpu_mask_high = 1'b0;
      cpu_mask_low = 1'b0;
      drive = '1;
      repeat (5) @(posedge clock);
      rst <= 1'b0;
      @(posedge clock);
      for (int a = 0; a < 12; a++) rd(8'(a), 8'h00);
      wr(EXIP_OFS_GH_SENS, 8'hFF);
      wr(EXIP_OFS_LINE_SENS_LO, 8'hFF);
      cpu_mask_high <= 1'b1;
      wr(EXIP_OFS_GH_SENS, 8'hFF);
      rd(EXIP_OFS_GH_SENS, 8'h00);
      rd(EXIP_OFS_LINE_SENS_LO, 8'h00);
      cpu_mask_low <= 1'b1;
      wr(EXIP_OFS_GH_SENS, 8'hFF);
      rd(EXIP_OFS_GH_SENS, 8'h0F);
      wr(EXIP_OFS_ROUTE_B, 8'hFF);
      rd(EXIP_OFS_ROUTE_B, 8'h7F);
      bus_req.rd <= 1'b1;
      bus_req.addr <= EXIP_OFS_GH_SENS;
      @(posedge clock);
      bus_req.rd <= 1'b0;
      #1 check(med_rdata, 8'h00);
      check(bus_rdata, 8'h0F);
      @(posedge clock);
      bus_req.rd <= 1'b1;
      bus_req.addr <= EXIP_OFS_ROUTE_B;
      @(posedge clock);
      bus_req.rd <= 1'b0;
      #1 check(med_rdata, 8'h00);
      @(posedge clock);
      wr(8'h07, 8'hFF);
      rd(8'h07, 8'h00);
      // Lines 0..3 get codes 00, 01, 10, 11
      wr(EXIP_OFS_LINE_SENS_LO, 8'hE4);
      rd(EXIP_OFS_LINE_SENS_LO, 8'hE4);
      drive.a <= 8'hF0;
      repeat (3) @(posedge clock);
      rd(EXIP_OFS_LINE_FLAGS, 8'h0D);
      wr(EXIP_OFS_LINE_FLAGS, 8'hFF);
      rd(EXIP_OFS_LINE_FLAGS, 8'h01);
      drive.a <= 8'hFF;
      repeat (3) @(posedge clock);
      rd(EXIP_OFS_LINE_FLAGS, 8'h0B);
      wr(EXIP_OFS_LINE_FLAGS, 8'h0A);
      rd(EXIP_OFS_LINE_FLAGS, 8'h01);
      wr(EXIP_OFS_LINE_FLAGS, 8'h01);
      rd(EXIP_OFS_LINE_FLAGS, 8'h00);
      wr(EXIP_OFS_LINE_SENS_LO, 8'hAA);
      wr(EXIP_OFS_LINE_SENS_HI, 8'hAA);
      wr(EXIP_OFS_PORT_SENS, 8'hAA);
      wr(EXIP_OFS_GH_SENS, 8'h0A);
      // Low half of each port to its own irq, high half stays on the lines
      for (int k = 0; k < 6; k++) begin
         wr(EXIP_OFS_ROUTE_A, ra[k]);
         wr(EXIP_OFS_ROUTE_B, rb[k]);
         drive[pbyte[k] * 8 +: 8] <= 8'hDD;
         repeat (3) @(posedge clock);
         rd(EXIP_OFS_LINE_FLAGS, 8'h20);
         rd(EXIP_OFS_PORT_FLAGS, 8'(1 << k));
         #1 check({5'h00, irq[2:0]}, {5'h00, eirq[k]});
         drive <= '1;
         wr(EXIP_OFS_PORT_FLAGS, 8'h00);
         rd(EXIP_OFS_PORT_FLAGS, 8'(1 << k));
         wr(EXIP_OFS_LINE_FLAGS, 8'hFF);
         wr(EXIP_OFS_PORT_FLAGS, 8'hFF);
         rd(EXIP_OFS_PORT_FLAGS, 8'h00);
         #1 check({5'h00, irq[2:0]}, 8'h00);
      end
      print_verdict();
   end
endmodule
